// ---- design/mpc_channel.sv ----
`timescale 1ns/1ns
module mpc_channel
    import mpc_pkg::*;
#(
    parameter int unsigned GATE_CYC = GATE_CYCLES,
    parameter int unsigned SYNC_CYC = SYNC_SPACE_CYC,
    parameter bit          EVEN_CH  = 1'b1
)
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              in_a_i,
    input  wire logic              in_b_i,
    input  wire logic              in_aux_i,
    input  wire logic [2:0]        mode_i,
    input  wire logic              sync_valid_i,
    input  wire logic              count_permit_i,
    input  wire logic              aux_gate_en_i,
    input  wire logic [CNT_W-1:0]  preset_i,
    input  wire logic [TMR_W-1:0]  interval_i,
    input  wire logic [FILT_W-1:0] aux_filter_i,
    output logic [CNT_W-1:0]       count_o,
    output logic [HALF_W-1:0]      count_lo_o,
    output logic [HALF_W-1:0]      count_hi_o,
    output logic [FREQ_W-1:0]      freq_o,
    output logic [CNT_W-1:0]       event_total_o,
    output logic                   event_done_o,
    output logic                   at_zero_o,
    output logic                   wrap_o,
    output logic                   partner_off_o
);

    mpc_mode_t        mode;
    logic             a_s1_q, a_s2_q, a_s3_q;
    logic             b_s1_q, b_s2_q, b_s3_q;
    logic             a_rise;
    logic             b_rise;
    logic             aux_lvl;
    logic             aux_rise;
    logic             aux_fall;
    logic             aux_busy;
    logic             w32_ok;
    logic [CNT_W-1:0] cnt_q;
    logic [FREQ_W-1:0] fcnt_q;
    logic [TMR_W-1:0] gate_q;
    logic [TMR_W-1:0] hi_q;
    logic             long_seen_q;
    logic [TMR_W-1:0] since_q;
    logic             ev_pulse;
    logic [CNT_W-1:0] ev_q;
    logic [TMR_W-1:0] iv_q;
    logic             armed_q;

    assign mode   = mpc_mode_t'(mode_i);
    // 32-bit pairing exists only on even channels
    assign w32_ok = EVEN_CH && (mode == MPC_MODE_W32);

    // saturating step: keeps counter inside the mode's signed window
    function automatic logic [CNT_W-1:0] step_sat(input logic [CNT_W-1:0] v,
                                                 input logic up,
                                                 input logic [CNT_W-1:0] hi,
                                                 input logic [CNT_W-1:0] lo);
        logic [CNT_W-1:0] r;
        r = v;
        if (up && ($signed(v) < $signed(hi)))
            r = v + CNT_ONE;
        else if (!up && ($signed(v) > $signed(lo)))
            r = v - CNT_ONE;
        return r;
    endfunction : step_sat

    // ****************************************
    // input synchronisers and edges
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            a_s3_q <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            b_s3_q <= 1'b0;
        end
        else
        begin
            a_s1_q <= in_a_i;
            a_s2_q <= a_s1_q;
            a_s3_q <= a_s2_q;
            b_s1_q <= in_b_i;
            b_s2_q <= b_s1_q;
            b_s3_q <= b_s2_q;
        end
    end

    assign a_rise = a_s2_q & ~a_s3_q;
    assign b_rise = b_s2_q & ~b_s3_q;

    // programmable filter delay on the auxiliary input
    mpc_filter u_aux_filter
    (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .pin_i   (in_aux_i),
        .level_i (aux_filter_i),
        .lvl_o   (aux_lvl),
        .rise_o  (aux_rise),
        .fall_o  (aux_fall),
        .busy_o  (aux_busy)
    );

    // ****************************************
    // frequency meter: one-second gate
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            gate_q <= '0;
            fcnt_q <= '0;
            freq_o <= '0;
        end
        else if (mode != MPC_MODE_FREQ)
        begin
            gate_q <= '0;
            fcnt_q <= '0;
        end
        else if (gate_q >= TMR_W'(GATE_CYC - 1))
        begin
            gate_q <= '0;
            // pulses per second equals hertz, 1 Hz resolution
            freq_o <= fcnt_q + FREQ_W'(a_rise);
            fcnt_q <= '0;
        end
        else
        begin
            gate_q <= gate_q + 1'b1;
            fcnt_q <= fcnt_q + FREQ_W'(a_rise);
        end
    end

    // ****************************************
    // event qualification: width and spacing
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hi_q        <= '0;
            long_seen_q <= 1'b0;
            since_q     <= '0;
        end
        else
        begin
            // no debounce: width timer restarts on any low sample
            if (!a_s2_q)
            begin
                hi_q        <= '0;
                long_seen_q <= 1'b0;
            end
            else if (hi_q < TMR_W'(MIN_PULSE_CYC))
                hi_q <= hi_q + 1'b1;
            else
                long_seen_q <= 1'b1;
            // spacing restarts even when the aux gate drops the pulse
            if (ev_pulse)
                since_q <= '0;
            else if (since_q < TMR_W'(SYNC_CYC))
                since_q <= since_q + 1'b1;
        end
    end

    // pulse counted once it outlasts the minimum width
    assign ev_pulse = a_s2_q && (hi_q >= TMR_W'(MIN_PULSE_CYC)) && !long_seen_q
                      && (since_q >= TMR_W'(SYNC_CYC));

    // ****************************************
    // event counting over user interval
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ev_q          <= '0;
            iv_q          <= '0;
            event_total_o <= '0;
            event_done_o  <= 1'b0;
        end
        else
        begin
            event_done_o <= 1'b0;
            if (mode != MPC_MODE_EVENT)
            begin
                ev_q <= '0;
                iv_q <= '0;
            end
            else if (iv_q >= interval_i)
            begin
                event_total_o <= ev_q;
                event_done_o  <= 1'b1;
                ev_q          <= '0;
                iv_q          <= '0;
            end
            else
            begin
                iv_q <= iv_q + 1'b1;
                // gate applies only when enabled
                if (ev_pulse && (!aux_gate_en_i || aux_lvl))
                    ev_q <= ev_q + CNT_ONE;
            end
        end
    end

    // ****************************************
    // sync-validate arming for preset loads
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            armed_q <= 1'b0;
        else
            armed_q <= sync_valid_i;
    end

    // ****************************************
    // main counter
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q  <= CNT_ZERO;
            wrap_o <= 1'b0;
        end
        else
        begin
            wrap_o <= 1'b0;
            case (mode)
                MPC_MODE_DOWN:
                begin
                    // either aux edge reloads; load beats a same-cycle decrement
                    if (armed_q && (aux_rise || aux_fall))
                        cnt_q <= preset_i;
                    else if (a_rise && count_permit_i && (cnt_q != CNT_ZERO))
                        cnt_q <= cnt_q - CNT_ONE;
                    // zero is held until a reload
                    else
                        cnt_q <= cnt_q;
                end
                MPC_MODE_MODULO:
                begin
                    if (a_rise)
                    begin
                        if (cnt_q >= preset_i)
                        begin
                            cnt_q  <= CNT_ZERO;
                            wrap_o <= 1'b1;
                        end
                        else
                            cnt_q <= cnt_q + CNT_ONE;
                    end
                end
                MPC_MODE_UPDOWN:
                begin
                    // a wider value carried in from another mode is clamped first
                    if ($signed(cnt_q) > $signed(UD_MAX))
                        cnt_q <= UD_MAX;
                    else if ($signed(cnt_q) < $signed(UD_MIN))
                        cnt_q <= UD_MIN;
                    // pulses dropped while direction change is filtered
                    else if (a_rise && !aux_busy)
                        cnt_q <= step_sat(cnt_q, aux_lvl, UD_MAX, UD_MIN);
                end
                MPC_MODE_W32:
                begin
                    if (!w32_ok)
                        cnt_q <= CNT_ZERO;
                    // preset load wins over a same-cycle count
                    else if (armed_q && aux_rise)
                        cnt_q <= preset_i;
                    // simultaneous a and b edges cancel out
                    else if (a_rise && !b_rise)
                        cnt_q <= step_sat(cnt_q, 1'b1, W32_MAX, W32_MIN);
                    else if (b_rise && !a_rise)
                        cnt_q <= step_sat(cnt_q, 1'b0, W32_MAX, W32_MIN);
                end
                default:
                begin
                    cnt_q <= cnt_q;
                end
            endcase
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            count_o       <= CNT_ZERO;
            count_lo_o    <= '0;
            count_hi_o    <= '0;
            at_zero_o     <= 1'b1;
            partner_off_o <= 1'b0;
        end
        else
        begin
            count_o       <= cnt_q;
            // halves pair into one 32-bit value
            count_lo_o    <= cnt_q[HALF_W-1:0];
            count_hi_o    <= cnt_q[CNT_W-1:HALF_W];
            at_zero_o     <= (cnt_q == CNT_ZERO);
            partner_off_o <= w32_ok;
        end
    end

endmodule : mpc_channel

// ---- shared/mpc_pkg.sv ----
package mpc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned GATE_TIME_S     = 1;
    localparam int unsigned GATE_CYCLES     = CLK_HZ * GATE_TIME_S;
    localparam int unsigned MIN_PULSE_US    = 50;
    localparam int unsigned MIN_PULSE_CYC   = (MIN_PULSE_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
    localparam int unsigned SYNC_SPACE_MS   = 100;
    localparam int unsigned SYNC_SPACE_CYC  = (SYNC_SPACE_MS * 1000_000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
    localparam int unsigned FILT_STEP_US    = 1;
    localparam int unsigned FILT_STEP_CYC   = (FILT_STEP_US * 1000) / CLK_PERIOD_NS;

    // ****************************************
    // widths and limits
    // ****************************************
    localparam int unsigned CNT_W      = 32;
    localparam int unsigned FREQ_W     = 32;
    localparam int unsigned HALF_W     = 16;
    localparam int unsigned FILT_W     = 8;
    localparam int unsigned TMR_W      = 32;
    localparam logic [CNT_W-1:0] UD_MAX   = 32'h0000_FFFF;
    localparam logic [CNT_W-1:0] UD_MIN   = 32'hFFFF_0000;
    localparam logic [CNT_W-1:0] W32_MAX  = 32'h7FFF_FFFF;
    localparam logic [CNT_W-1:0] W32_MIN  = 32'h8000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

    // ****************************************
    // modes
    // ****************************************
    typedef enum logic [2:0]
    {
        MPC_MODE_FREQ   = 3'h0,
        MPC_MODE_EVENT  = 3'h1,
        MPC_MODE_DOWN   = 3'h3,
        MPC_MODE_MODULO = 3'h2,
        MPC_MODE_UPDOWN = 3'h6,
        MPC_MODE_W32    = 3'h7
    } mpc_mode_t;

endpackage : mpc_pkg

// ---- design/mpc_filter.sv ----
`timescale 1ns/1ns
// two-flop sync, then programmable stability filter with edge pulses
module mpc_filter
    import mpc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              pin_i,
    input  wire logic [FILT_W-1:0] level_i,
    output logic                   lvl_o,
    output logic                   rise_o,
    output logic                   fall_o,
    output logic                   busy_o
);

    logic              s1_q;
    logic              s2_q;
    logic              lvl_q;
    logic [FILT_W-1:0] cnt_q;
    logic [TMR_W-1:0]  step_q;

    // ****************************************
    // synchroniser
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
        end
    end

    // ****************************************
    // filter: input must hold level_i steps
    // ****************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lvl_q  <= 1'b0;
            cnt_q  <= '0;
            step_q <= '0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end
        else
        begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (s2_q == lvl_q)
            begin
                cnt_q  <= '0;
                step_q <= '0;
            end
            else if (cnt_q >= level_i)
            begin
                lvl_q  <= s2_q;
                rise_o <= s2_q;
                fall_o <= ~s2_q;
                cnt_q  <= '0;
                step_q <= '0;
            end
            else if (step_q >= TMR_W'(FILT_STEP_CYC - 1))
            begin
                step_q <= '0;
                cnt_q  <= cnt_q + 1'b1;
            end
            else
            begin
                step_q <= step_q + 1'b1;
            end
        end
    end

    assign lvl_o  = lvl_q;
    // pending change: up/down mode ignores count input meanwhile
    assign busy_o = (s2_q != lvl_q);

endmodule : mpc_filter

// ---- tb/mpc_channel_sva.sv ----
`timescale 1ns/1ns
module mpc_channel_sva
    import mpc_pkg::*;
#(
    parameter bit EVEN_CH = 1'b1
)
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [2:0]        mode_i,
    input  wire logic              count_permit_i,
    input  wire logic [CNT_W-1:0]  preset_i,
    input  wire logic [CNT_W-1:0]  count_o,
    input  wire logic [HALF_W-1:0] count_lo_o,
    input  wire logic [HALF_W-1:0] count_hi_o,
    input  wire logic              event_done_o,
    input  wire logic              at_zero_o,
    input  wire logic              wrap_o,
    input  wire logic              partner_off_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_ZERO_FLAG: assert property (count_o == 0 && $past(count_o) == 0 |-> at_zero_o)
        else $error("zero flag low while counter rests at zero");
    AST_HALVES: assert property ({count_hi_o, count_lo_o} == count_o)
        else $error("counter halves disagree with full value");
    AST_UD_RANGE: assert property (mode_i == MPC_MODE_UPDOWN |->
        $signed(count_o) >= -65536 && $signed(count_o) <= 65535)
        else $error("up/down count out of range");
    AST_PARTNER: assert property (1'b1 |=>
        partner_off_o == (EVEN_CH && $past(mode_i) == MPC_MODE_W32))
        else $error("partner-off level wrong for mode");
    AST_PERMIT: assert property ((mode_i == MPC_MODE_DOWN && !count_permit_i) [*2] |=>
        count_o >= $past(count_o))
        else $error("decrement without count permit");
    AST_FLOOR: assert property (mode_i == MPC_MODE_DOWN && $past(count_o) == 0 |->
        count_o == 0 || count_o == preset_i)
        else $error("downcounter left zero without reload");
    AST_MOD_LIMIT: assert property (mode_i == MPC_MODE_MODULO && $past(mode_i) == MPC_MODE_MODULO
        |-> count_o <= preset_i)
        else $error("modulo count above preset");
    AST_WRAP_ZERO: assert property ($rose(wrap_o) |-> ##[0:2] count_o == 0)
        else $error("wrap without clear to zero");
    AST_DONE_PULSE: assert property ($rose(event_done_o) |=> !event_done_o [*4])
        else $error("interval done not a single pulse");
endmodule : mpc_channel_sva

bind mpc_channel mpc_channel_sva #(.EVEN_CH(EVEN_CH)) i_sva
(
    .clk_i          (clk_i),
    .rstn_i         (rstn_i),
    .mode_i         (mode_i),
    .count_permit_i (count_permit_i),
    .preset_i       (preset_i),
    .count_o        (count_o),
    .count_lo_o     (count_lo_o),
    .count_hi_o     (count_hi_o),
    .event_done_o   (event_done_o),
    .at_zero_o      (at_zero_o),
    .wrap_o         (wrap_o),
    .partner_off_o  (partner_off_o)
);

// ---- tb/mpc_field_src.sv ----
`timescale 1ns/1ns
module mpc_field_src
(
    input  wire logic clk_i,
    output logic      in_a_o,
    output logic      in_b_o,
    output logic      aux_o
);
    // ****************************************
    // field pulse source
    // ****************************************
    // rates are scaled up to keep the run short; only event mode checks pulse width and spacing
    initial
    begin
        in_a_o = 1'b0;
        in_b_o = 1'b0;
        aux_o  = 1'b0;
    end

    // caller picks high/low times to suit the mode's rate and duty limits
    task automatic pulse(input bit sel_b, input int hi, input int lo, input int n);
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk_i);
            if (sel_b)
                in_b_o <= 1'b1;
            else
                in_a_o <= 1'b1;
            repeat (hi) @(posedge clk_i);
            in_a_o <= 1'b0;
            in_b_o <= 1'b0;
            repeat (lo) @(posedge clk_i);
        end
    endtask : pulse

    // aux level held at least hold cycles before the next change
    task automatic set_aux(input logic v, input int hold);
        @(posedge clk_i);
        aux_o <= v;
        repeat (hold) @(posedge clk_i);
    endtask : set_aux
endmodule : mpc_field_src

// ---- tb/mpc_channel_tb_top.sv ----
`timescale 1ns/1ns
module mpc_channel_tb_top
    import mpc_pkg::*;
;
    logic              clk_i = 1'b0;
    logic              rstn_i;
    logic              in_a, in_b, in_aux;
    logic [2:0]        mode_i;
    logic              sync_valid_i, count_permit_i, aux_gate_en_i;
    logic [CNT_W-1:0]  preset_i;
    logic [TMR_W-1:0]  interval_i;
    logic [FILT_W-1:0] aux_filter_i;
    logic [CNT_W-1:0]  count_o, event_total_o;
    logic [HALF_W-1:0] count_lo_o, count_hi_o;
    logic [FREQ_W-1:0] freq_o;
    logic              event_done_o, at_zero_o, wrap_o, partner_off_o;
    int                fail_count = 0;
    int                num_checks = 0;
    int                exp;
    logic [31:0]       seed = 32'h0000_025b;

    always #5 clk_i = ~clk_i;

    mpc_channel #(.GATE_CYC(10000), .SYNC_CYC(6000), .EVEN_CH(1'b1)) i_dut
    (
        .clk_i(clk_i), .rstn_i(rstn_i), .in_a_i(in_a), .in_b_i(in_b), .in_aux_i(in_aux),
        .mode_i(mode_i), .sync_valid_i(sync_valid_i), .count_permit_i(count_permit_i),
        .aux_gate_en_i(aux_gate_en_i), .preset_i(preset_i), .interval_i(interval_i),
        .aux_filter_i(aux_filter_i), .count_o(count_o), .count_lo_o(count_lo_o),
        .count_hi_o(count_hi_o), .freq_o(freq_o), .event_total_o(event_total_o),
        .event_done_o(event_done_o), .at_zero_o(at_zero_o), .wrap_o(wrap_o),
        .partner_off_o(partner_off_o)
    );

    mpc_field_src i_src (.clk_i(clk_i), .in_a_o(in_a), .in_b_o(in_b), .aux_o(in_aux));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk_v(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want)
        begin
            fail_count++;
            $display("unexpected value at %0t: got %08h want %08h", $time, got, want);
        end
    endtask : chk_v

    task automatic chk_f(input logic got, input logic want);
        num_checks++;
        if (got !== want)
        begin
            fail_count++;
            $display("unexpected flag at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk_f

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // pin edge to count_o is about 4 cycles; 12 leaves margin
    task automatic settle();
        repeat (12) @(posedge clk_i);
    endtask : settle

    task automatic do_reset(input logic [2:0] m);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        mode_i <= m;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        exp = 0;
        settle();
    endtask : do_reset

    task automatic wait_done();
        int k;
        for (k = 0; k < 20000 && event_done_o !== 1'b1; k++)
            @(negedge clk_i);
        if (k == 20000)
        begin
            fail_count++;
            close_out();
        end
    endtask : wait_done

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        rstn_i = 1'b0;
        mode_i = MPC_MODE_FREQ;
        sync_valid_i = 1'b0;
        count_permit_i = 1'b0;
        aux_gate_en_i = 1'b0;
        preset_i = 32'h0000_0005;
        interval_i = 32'h0000_3E80;
        aux_filter_i = 8'h00;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        settle();
        chk_v(count_o, 32'h0000_0000);
        chk_f(at_zero_o, 1'b1);
        chk_f(partner_off_o, 1'b0);
        // 50 kHz, 50 % duty: five rising edges in every gate window
        i_src.pulse(1'b0, 1000, 1000, 13);
        chk_v(freq_o, 32'h0000_0005);
        // downcounting
        sync_valid_i <= 1'b1;
        count_permit_i <= 1'b1;
        do_reset(MPC_MODE_DOWN);
        i_src.set_aux(1'b1, 12);
        exp = 5;
        chk_v(count_o, exp[31:0]);
        i_src.pulse(1'b0, 4, 12, 3);
        exp -= 3;
        chk_v(count_o, exp[31:0]);
        count_permit_i <= 1'b0;
        i_src.pulse(1'b0, 4, 12, 2);
        chk_v(count_o, exp[31:0]);
        count_permit_i <= 1'b1;
        i_src.pulse(1'b0, 4, 12, 4);
        exp = 0;
        chk_v(count_o, exp[31:0]);
        chk_f(at_zero_o, 1'b1);
        repeat (10000) @(posedge clk_i);
        i_src.set_aux(1'b0, 12);
        exp = 5;
        chk_v(count_o, exp[31:0]);
        // modulo wrap at preset 3
        // scaled rate, so a small modulo brings a wrap within the six pulses
        preset_i <= 32'h0000_0003;
        do_reset(MPC_MODE_MODULO);
        for (int i = 0; i < 6; i++)
        begin
            i_src.pulse(1'b0, 4, 12, 1);
            exp = (exp >= 3) ? 0 : exp + 1;
            chk_v(count_o, exp[31:0]);
        end
        // up/down with direction filter
        aux_filter_i <= 8'h01;
        do_reset(MPC_MODE_UPDOWN);
        i_src.set_aux(1'b1, 150);
        i_src.pulse(1'b0, 4, 12, 3);
        exp = 3;
        chk_v(count_o, exp[31:0]);
        i_src.set_aux(1'b0, 1);
        i_src.pulse(1'b0, 4, 12, 1);
        chk_v(count_o, exp[31:0]);
        repeat (150) @(posedge clk_i);
        aux_filter_i <= 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            i_src.set_aux(seed[0], 6);
            i_src.pulse(1'b0, 4, 12, 1);
            exp += seed[0] ? 1 : -1;
            chk_v(count_o, exp[31:0]);
        end
        // event totals: short pulse is dropped
        do_reset(MPC_MODE_EVENT);
        wait_done();
        i_src.pulse(1'b0, 5500, 100, 1);
        i_src.pulse(1'b0, 2000, 100, 1);
        i_src.pulse(1'b0, 5500, 100, 1);
        wait_done();
        chk_v(event_total_o, 32'h0000_0002);
        // second long pulse falls inside the spacing window
        i_src.pulse(1'b0, 5500, 100, 2);
        wait_done();
        chk_v(event_total_o, 32'h0000_0001);
        // gate enabled with aux low: long pulse is not totalled
        i_src.set_aux(1'b0, 12);
        interval_i <= 32'h0000_1770;
        aux_gate_en_i <= 1'b1;
        i_src.pulse(1'b0, 5500, 100, 1);
        wait_done();
        chk_v(event_total_o, 32'h0000_0000);
        // 32-bit: a up, b down, preset crosses the half boundary
        i_src.set_aux(1'b0, 12);
        preset_i <= 32'hFFFF_FFFE;
        do_reset(MPC_MODE_W32);
        chk_f(partner_off_o, 1'b1);
        i_src.pulse(1'b0, 4, 12, 3);
        i_src.pulse(1'b1, 4, 12, 1);
        exp = 2;
        chk_v(count_o, exp[31:0]);
        i_src.set_aux(1'b1, 12);
        exp = 32'hFFFF_FFFE;
        chk_v(count_o, exp[31:0]);
        i_src.pulse(1'b0, 4, 12, 4);
        exp += 4;
        chk_v({count_hi_o, count_lo_o}, exp[31:0]);
        close_out();
    end
endmodule : mpc_channel_tb_top
